// ### verilog/ssf_pkg.sv
// Package for the sample status flag block: register map, bit layout, carriers.
// Assumes a single 20 MHz system clock and a synchronous active-low reset.
package ssf_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] SSF_ADDR_ALIAS     = 8'h00;
  localparam logic [7:0] SSF_ADDR_PRESS_HI  = 8'h01;
  localparam logic [7:0] SSF_ADDR_FIFO_DATA = 8'h01;
  localparam logic [7:0] SSF_ADDR_TEMP_HI   = 8'h04;
  localparam logic [7:0] SSF_ADDR_STATUS    = 8'h06;
  localparam logic [7:0] SSF_STATUS_RESET   = 8'h00;

  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int SSF_BIT_ANY_OW  = 7;
  localparam int SSF_BIT_PRESS_OW = 6;
  localparam int SSF_BIT_TEMP_OW = 5;
  localparam int SSF_BIT_ANY_RDY = 3;
  localparam int SSF_BIT_PRESS_RDY = 2;
  localparam int SSF_BIT_TEMP_RDY = 1;

  localparam logic [1:0] SSF_FIFO_OFF = 2'h0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       rd_stb;
    logic [7:0] rd_addr;
  } ssf_rd_s;

  typedef struct packed {
    logic press_event_enable;
    logic temp_event_enable;
    logic ready_event_mode;
  } ssf_cfg_s;

endpackage

// ### verilog/ssf_flag_pair.sv
// One ready flag and its overwrite flag for a single measurement channel.
// Assumes set and clear strobes are one-cycle pulses on clk_sys_i.
`timescale 1ns/1ps
module ssf_flag_pair
(
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic enable_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      ready_o,
  output logic      overwrite_o
);

  logic ready_r;
  logic ready_nxt;
  logic ow_r;
  logic ow_nxt;

  // Set beats clear so an event in the clear cycle survives
  always_comb
  begin
    ready_nxt = ready_r;
    ow_nxt    = ow_r;
    if (clr_i)
    begin
      ready_nxt = 1'b0;
      ow_nxt    = 1'b0;
    end
    if (set_i && enable_i)
    begin
      ready_nxt = 1'b1;
      ow_nxt    = ow_r | ready_r;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      ready_r <= 1'b0;
      ow_r    <= 1'b0;
    end
    else
    begin
      ready_r <= ready_nxt;
      ow_r    <= ow_nxt;
    end
  end

  assign ready_o     = ready_r;
  assign overwrite_o = ow_r;

endmodule

// ### verilog/ssf_any_flags.sv
// Combined ready and overwrite flags covering both channels.
// Assumes set and clear strobes are one-cycle pulses on clk_sys_i.
`timescale 1ns/1ps
module ssf_any_flags
(
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic enable_i,
  input  wire logic press_set_i,
  input  wire logic temp_set_i,
  input  wire logic clr_i,
  output logic      ready_o,
  output logic      overwrite_o
);

  logic ready_r;
  logic ready_nxt;
  logic ow_r;
  logic ow_nxt;
  logic set;

  assign set = press_set_i | temp_set_i;

  always_comb
  begin
    ready_nxt = ready_r;
    ow_nxt    = ow_r;
    if (clr_i)
    begin
      ready_nxt = 1'b0;
      ow_nxt    = 1'b0;
    end
    if (set && enable_i)
    begin
      ready_nxt = 1'b1;
      ow_nxt    = ow_r | ready_r;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      ready_r <= 1'b0;
      ow_r    <= 1'b0;
    end
    else
    begin
      ready_r <= ready_nxt;
      ow_r    <= ow_nxt;
    end
  end

  assign ready_o     = ready_r;
  assign overwrite_o = ow_r;

endmodule

// ### verilog/ssf_top.sv
// Sample status register: per-channel and combined ready/overwrite flags.
// Assumes the register read path supplies a one-cycle read strobe with address.
`timescale 1ns/1ps
module ssf_top
(
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire ssf_pkg::ssf_rd_s  rd_i,
  input  wire ssf_pkg::ssf_cfg_s cfg_i,
  input  wire logic [1:0]        fifo_mode_i,
  input  wire logic              press_done_i,
  input  wire logic              temp_done_i,
  output logic                   status_hit_o,
  output logic [7:0]             status_data_o
);

  // ****************************************************************
  // Read decode
  // ****************************************************************
  logic fifo_off;
  logic press_hi_rd;
  logic temp_hi_rd;
  logic fifo_rd;
  logic press_clr;
  logic temp_clr;
  logic any_clr;

  assign fifo_off = (fifo_mode_i == ssf_pkg::SSF_FIFO_OFF);

  always_comb
  begin
    press_hi_rd  = 1'b0;
    temp_hi_rd   = 1'b0;
    fifo_rd      = 1'b0;
    status_hit_o = 1'b0;
    if (rd_i.rd_stb && rd_i.rd_addr == ssf_pkg::SSF_ADDR_STATUS)
    begin
      status_hit_o = 1'b1;
    end
    else if (rd_i.rd_stb && fifo_off && rd_i.rd_addr == ssf_pkg::SSF_ADDR_ALIAS)
    begin
      status_hit_o = 1'b1;
    end
    else if (rd_i.rd_stb && fifo_off && rd_i.rd_addr == ssf_pkg::SSF_ADDR_PRESS_HI)
    begin
      press_hi_rd = 1'b1;
    end
    else if (rd_i.rd_stb && fifo_off && rd_i.rd_addr == ssf_pkg::SSF_ADDR_TEMP_HI)
    begin
      temp_hi_rd = 1'b1;
    end
    else if (rd_i.rd_stb && !fifo_off && rd_i.rd_addr == ssf_pkg::SSF_ADDR_FIFO_DATA)
    begin
      fifo_rd = 1'b1;
    end
  end

  assign press_clr = press_hi_rd | fifo_rd;
  assign temp_clr  = temp_hi_rd | fifo_rd;
  assign any_clr   = press_hi_rd | temp_hi_rd | fifo_rd;

  // ****************************************************************
  // Flags
  // ****************************************************************
  logic press_rdy;
  logic press_ow;
  logic temp_rdy;
  logic temp_ow;
  logic any_rdy;
  logic any_ow;

  ssf_flag_pair u_press
  (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .enable_i    (cfg_i.press_event_enable),
    .set_i       (press_done_i),
    .clr_i       (press_clr),
    .ready_o     (press_rdy),
    .overwrite_o (press_ow)
  );

  ssf_flag_pair u_temp
  (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .enable_i    (cfg_i.temp_event_enable),
    .set_i       (temp_done_i),
    .clr_i       (temp_clr),
    .ready_o     (temp_rdy),
    .overwrite_o (temp_ow)
  );

  ssf_any_flags u_any
  (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .enable_i    (cfg_i.ready_event_mode),
    .press_set_i (press_done_i),
    .temp_set_i  (temp_done_i),
    .clr_i       (any_clr),
    .ready_o     (any_rdy),
    .overwrite_o (any_ow)
  );

  // ****************************************************************
  // Status image
  // ****************************************************************
  logic [7:0] status_r;
  logic [7:0] status_nxt;

  always_comb
  begin
    status_nxt = ssf_pkg::SSF_STATUS_RESET;
    status_nxt[ssf_pkg::SSF_BIT_ANY_OW]    = any_ow;
    status_nxt[ssf_pkg::SSF_BIT_PRESS_OW]  = press_ow;
    status_nxt[ssf_pkg::SSF_BIT_TEMP_OW]   = temp_ow;
    status_nxt[ssf_pkg::SSF_BIT_ANY_RDY]   = any_rdy;
    status_nxt[ssf_pkg::SSF_BIT_PRESS_RDY] = press_rdy;
    status_nxt[ssf_pkg::SSF_BIT_TEMP_RDY]  = temp_rdy;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      status_r <= ssf_pkg::SSF_STATUS_RESET;
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  assign status_data_o = status_r;

endmodule

// ### sim/ssf_top_properties.sv
// Checker for the status flag block, bound to ssf_top.
// Assumes a cause at one edge shows in the status byte two edges later.
`timescale 1ns/1ps
module ssf_top_properties
(
  input wire logic              clk_sys_i,
  input wire logic              nrst_i,
  input wire ssf_pkg::ssf_rd_s  rd_i,
  input wire ssf_pkg::ssf_cfg_s cfg_i,
  input wire logic [1:0]        fifo_mode_i,
  input wire logic              press_done_i,
  input wire logic              temp_done_i,
  input wire logic              status_hit_o,
  input wire logic [7:0]        status_data_o
);
  // ********
  // Properties
  // ********
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // Events only count when the design sees reset released at that edge
  wire logic ps = press_done_i && cfg_i.press_event_enable && nrst_i;
  wire logic ts = temp_done_i && cfg_i.temp_event_enable && nrst_i;
  wire logic ae = (press_done_i || temp_done_i) && cfg_i.ready_event_mode && nrst_i;
  wire logic qt = !press_done_i && !temp_done_i && rd_i.rd_stb;
  wire logic fo = fifo_mode_i == ssf_pkg::SSF_FIFO_OFF;
  a_spare_zero: assert property ((status_data_o & 8'h11) == 8'h00) else $error("spare bit");
  a_alias_hit: assert property (status_hit_o == (rd_i.rd_stb
    && (rd_i.rd_addr == 8'h06 || rd_i.rd_addr == 8'h00 && fo))) else $error("hit decode");
  a_press_set: assert property (ps |=> ##1 status_data_o[2]) else $error("press ready");
  a_press_over: assert property (ps ##1 ps |=> ##1 status_data_o[6]) else $error("press over");
  a_temp_over: assert property (ts ##1 ts |=> ##1 status_data_o[5]) else $error("temp over");
  a_any_over: assert property (ae ##1 ae |=> ##1 status_data_o[7]) else $error("any over");
  a_press_gate: assert property ($rose(status_data_o[2]) |-> $past(ps, 2)) else $error("press gate");
  a_temp_gate: assert property ($rose(status_data_o[1])
    |-> $past(temp_done_i && cfg_i.temp_event_enable, 2)) else $error("temp gate");
  a_any_gate: assert property ($rose(status_data_o[3])
    |-> $past(cfg_i.ready_event_mode && (press_done_i || temp_done_i), 2)) else $error("any gate");
  a_press_clear: assert property (qt && fo && rd_i.rd_addr == 8'h01
    |=> ##1 (status_data_o & 8'hCC) == 8'h00) else $error("press clear");
  a_temp_clear: assert property (qt && fo && rd_i.rd_addr == 8'h04
    |=> ##1 (status_data_o & 8'hAA) == 8'h00) else $error("temp clear");
  a_fifo_clear: assert property (qt && !fo && rd_i.rd_addr == 8'h01
    |=> ##1 (status_data_o & 8'hEE) == 8'h00) else $error("fifo clear");
endmodule

// ### sim/ssf_host.sv
// Host model: turns a bench read request into a one-cycle read strobe.
// Assumes requests arrive at rising edges; released address lines toggle.
`timescale 1ns/1ps
module ssf_host
(
  input  wire logic        clk_sys_i,
  input  wire logic        req_i,
  input  wire logic [7:0]  addr_i,
  output ssf_pkg::ssf_rd_s rd_o
);
  initial rd_o = '0;
  always @(posedge clk_sys_i)
  begin
    rd_o.rd_stb <= req_i;
    rd_o.rd_addr <= req_i ? addr_i : ~rd_o.rd_addr;
  end
endmodule

// ### sim/sample_status_flags_tb.sv
// Self-checking bench for ssf_top against a flag model.
// Assumes ssf_pkg, ssf_host and the checker are compiled first.
`timescale 1ns/1ps
module sample_status_flags_tb;
  logic              clk_sys_i = 1'b0;
  logic              nrst_i = 1'b0;
  ssf_pkg::ssf_cfg_s cfg = '0;
  ssf_pkg::ssf_rd_s  rd;
  logic [1:0]        fifo = 2'h0;
  logic              pd = 1'b0;
  logic              td = 1'b0;
  logic              req = 1'b0;
  logic              hit;
  logic              cp;
  logic              ct;
  logic [1:0]        p;
  logic [1:0]        t;
  logic [1:0]        a;
  logic [7:0]        addr = 8'h00;
  logic [7:0]        fl = 8'h00;
  logic [7:0]        sd_exp = 8'h00;
  logic [7:0]        sd;
  logic [31:0]       seed = 32'h1F;
  int                err_count = 0;
  int                total_checks = 0;
  int                cyc = 0;

  always #25 clk_sys_i = ~clk_sys_i;
  ssf_host i_host (.clk_sys_i(clk_sys_i), .req_i(req), .addr_i(addr), .rd_o(rd));
  ssf_top i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rd_i(rd), .cfg_i(cfg), .fifo_mode_i(fifo),
    .press_done_i(pd), .temp_done_i(td), .status_hit_o(hit), .status_data_o(sd));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Pair {overwrite, ready}: a set wins and overwrites a pending ready
  function automatic logic [1:0] ch(input logic [1:0] ro, input logic s, input logic c);
    return {s ? |ro : ro[1] & ~c, s | (ro[0] & ~c)};
  endfunction

  // ********
  // Reference model and comparisons
  // ********
  always @(posedge clk_sys_i)
  begin
    sd_exp <= nrst_i ? fl : 8'h00;
    cp = rd.rd_stb && rd.rd_addr == 8'h01;
    ct = rd.rd_stb && rd.rd_addr == (fifo == 2'h0 ? 8'h04 : 8'h01);
    p = ch({fl[6], fl[2]}, pd & cfg.press_event_enable, cp);
    t = ch({fl[5], fl[1]}, td & cfg.temp_event_enable, ct);
    a = ch({fl[7], fl[3]}, (pd | td) & cfg.ready_event_mode, cp | ct);
    fl = nrst_i ? {a[1], p[1], t[1], 1'b0, a[0], p[0], t[0], 1'b0} : 8'h00;
  end

  task chk(input logic ok, input string m);
    total_checks++;
    if (!ok)
    begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  always @(negedge clk_sys_i)
  begin
    cyc++;
    chk(sd === sd_exp, "status byte");
    chk(sd === sd_exp, "status flags");
    chk(hit === (rd.rd_stb && (rd.rd_addr == 8'h06 || rd.rd_addr == 8'h00 && fifo == 2'h0)), "hit");
    if (cyc == 6000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  task step(input logic [2:0] v, input logic [7:0] ad);
    @(posedge clk_sys_i);
    {pd, td, req} <= v;
    addr <= ad;
  endtask

  task rnd(input int n);
    repeat (n)
    begin
      seed = xs(seed);
      if (seed[12:8] == 5'h00) fifo <= seed[14:13];
      if (seed[15:10] == 6'h00) cfg <= seed[16] ? 3'h7 : seed[19:17];
      step({seed[0] & seed[1], seed[2] & seed[3], seed[4]}, {5'h00, seed[7:5]});
    end
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    cfg <= 3'h7;
    step(3'h4, 8'h00);
    step(3'h7, 8'h06);
    step(3'h3, 8'h04);
    step(3'h1, 8'h01);
    step(3'h0, 8'h00);
    fifo <= 2'h1;
    step(3'h7, 8'h01);
    step(3'h0, 8'h00);
    $display("test directed done");
    rnd(2000);
    $display("test random done");
    nrst_i <= 1'b0;
    rnd(4);
    nrst_i <= 1'b1;
    rnd(500);
    $display("test reset rerun done");
    tally_and_finish();
  end
endmodule

bind ssf_top ssf_top_properties i_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rd_i(rd_i), .cfg_i(cfg_i),
  .fifo_mode_i(fifo_mode_i), .press_done_i(press_done_i), .temp_done_i(temp_done_i),
  .status_hit_o(status_hit_o), .status_data_o(status_data_o));
